// >>> pkg/ieb_arb_if.sv
`timescale 1ns/100ps
`default_nettype none
// Gated requests and priorities out, winner back
interface ieb_arb_if;
	import ieb_pkg::*;
	logic [NUM_SRC-1:0]      req;        // Flag and enable both set
	logic [NUM_SRC-1:0][2:0] prio;       // Priority code per source
	logic                    win_valid;  // Some requesting source has a nonzero priority
	logic [5:0]              win_id;     // Winning source index
	logic [2:0]              win_level;  // Winning priority level
	modport bank (output req, prio, input win_valid, win_id, win_level);
	modport arb  (input req, prio, output win_valid, win_id, win_level);
endinterface
`default_nettype wire

// >>> pkg/ieb_pkg.sv
// Functional notes
// RQ1: Enable one passes request, zero blocks it
// RQ2: All enable bits clear at reset
// RQ3: Word1 bit2, word2 bit13 read zero
// RQ4: Word0 bits: compare1, capture1, pin0
// RQ5: Word1 high byte sources in order
// RQ6: Word1 low bits sources, i2c pair
// RQ7: Word2 timer6, dma4, compares, capture6
// RQ8: Word2 low byte sources in order
// RQ9: Enable bits read back last write
// RQ10: Flag sets on request, reads one
// RQ11: Three-bit priority, zero disables source
// RQ12: Forward only flag and enable; keep flag
`default_nettype none
package ieb_pkg;
	localparam int unsigned NUM_WORDS = 3;     // Enable words in bank
	localparam int unsigned NUM_SRC   = 48;    // Source slots, word*16+bit
	localparam int unsigned NUM_PROWS = 12;    // Priority rows, four fields each
	// Byte addresses on the APB
	localparam logic [11:0] ADDR_EN_BASE   = 12'h000;
	localparam logic [11:0] ADDR_FLAG_BASE = 12'h00c;
	localparam logic [11:0] ADDR_PRIO_BASE = 12'h020;
	localparam logic [11:0] ADDR_PRIO_END  = 12'h050;
	localparam logic [11:0] ADDR_STAT      = 12'h050;
	localparam logic [11:0] ADDR_STAT_CLR  = 12'h054;
	localparam logic [11:0] ADDR_STAT_EN   = 12'h058;
	localparam logic [11:0] ADDR_ARB       = 12'h05c;
	// Reset values
	localparam logic [15:0] EN_RST      = 16'h0000;
	localparam logic [15:0] FLAG_RST    = 16'h0000;
	localparam logic [2:0]  PRIO_RST    = 3'h4;
	localparam logic [2:0]  STAT_RST    = 3'h0;
	localparam logic [2:0]  PRIO_OFF    = 3'h0;  // Code that disables a source
	// Status bit positions
	localparam int unsigned ST_NEW_REQ = 0;     // A forwarded request appeared
	localparam int unsigned ST_OVERRUN = 1;     // Event hit an already set flag
	localparam int unsigned ST_BUS_ERR = 2;     // Access to unmapped address
	// Enable word 0 positions
	localparam int unsigned COMPARE1   = 2;
	localparam int unsigned CAPTURE1   = 1;
	localparam int unsigned EXT_PIN0   = 0;
	// Enable word 1 positions
	localparam int unsigned UART_B_TX  = 15;
	localparam int unsigned UART_B_RX  = 14;
	localparam int unsigned EXT_PIN2   = 13;
	localparam int unsigned TIMER5     = 12;
	localparam int unsigned TIMER4     = 11;
	localparam int unsigned COMPARE4   = 10;
	localparam int unsigned COMPARE3   = 9;
	localparam int unsigned DMA_CH2    = 8;
	localparam int unsigned CAPTURE8   = 7;
	localparam int unsigned CAPTURE7   = 6;
	localparam int unsigned CONV_B     = 5;
	localparam int unsigned EXT_PIN1   = 4;
	localparam int unsigned CHG_NOTIFY = 3;
	localparam int unsigned I2C_A_MST  = 1;
	localparam int unsigned I2C_A_SLV  = 0;
	// Enable word 2 positions
	localparam int unsigned TIMER6     = 15;
	localparam int unsigned DMA_CH4    = 14;
	localparam int unsigned COMPARE8   = 12;
	localparam int unsigned COMPARE7   = 11;
	localparam int unsigned COMPARE6   = 10;
	localparam int unsigned COMPARE5   = 9;
	localparam int unsigned CAPTURE6   = 8;
	localparam int unsigned CAPTURE5   = 7;
	localparam int unsigned CAPTURE4   = 6;
	localparam int unsigned CAPTURE3   = 5;
	localparam int unsigned DMA_CH3    = 4;
	localparam int unsigned CAN_A_EVT  = 3;
	localparam int unsigned CAN_A_RX   = 2;
	localparam int unsigned SPI_B_EVT  = 1;
	localparam int unsigned SPI_B_ERR  = 0;
endpackage
`default_nettype wire

// >>> src/ieb_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
// Picks the highest priority request, lowest index on a tie
module ieb_arbiter
	import ieb_pkg::*;
(
	ieb_arb_if.arb arb
);
	logic [2:0] best_lvl;  // Running best level
	logic [5:0] best_id;   // Running best source

	// Scan from top index down so lower index wins ties
	always_comb begin
		best_lvl = PRIO_OFF;
		best_id  = 6'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			// Code zero never competes
			if (arb.req[i] && (arb.prio[i] != PRIO_OFF) && (arb.prio[i] >= best_lvl)) begin // RQ11
				best_lvl = arb.prio[i];
				best_id  = 6'(i);
			end
		end
	end

	assign arb.win_valid = (best_lvl != PRIO_OFF);
	assign arb.win_id    = best_id;
	assign arb.win_level = best_lvl;
endmodule // ieb_arbiter
`default_nettype wire

// >>> src/ieb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Interrupt enable bank with flags, priorities and APB access
module ieb_top
	import ieb_pkg::*;
(
	input  wire logic                CLK,
	input  wire logic                RST,
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [11:0]         PADDR,
	input  wire logic [31:0]         PWDATA,
	output logic      [31:0]         PRDATA,
	output logic                     PREADY,
	output logic                     PSLVERR,
	input  wire logic [NUM_SRC-1:0]  SRC_EVENT,
	output logic      [NUM_SRC-1:0]  SRC_REQ,
	output logic                     ARB_VALID,
	output logic      [5:0]          ARB_ID,
	output logic      [2:0]          ARB_LEVEL,
	output logic                     IRQ
);
	// Single set bit at a position
	function automatic logic [15:0] bitv(input int unsigned p);
		return 16'h0001 << p;
	endfunction

	// Address compare against a word of a block
	function automatic logic reg_hit(input logic [11:0] a,
		input logic [11:0] base, input int unsigned idx);
		return a == (base + 12'(idx * 4));
	endfunction

	// Priority row as a 16-bit readback, gaps read zero
	function automatic logic [15:0] prio_row_rd(input logic [11:0] f);
		return {1'b0, f[11:9], 1'b0, f[8:6], 1'b0, f[5:3], 1'b0, f[2:0]};
	endfunction

	// State of the bank
	logic [NUM_WORDS-1:0][15:0]  en_ff;        // Enable words
	logic [NUM_WORDS-1:0][15:0]  nxt_en;
	logic [NUM_WORDS-1:0][15:0]  flag_ff;      // Request flags
	logic [NUM_WORDS-1:0][15:0]  nxt_flag;
	logic [NUM_SRC-1:0][2:0]     prio_ff;      // Priority codes
	logic [NUM_SRC-1:0][2:0]     nxt_prio;
	logic [2:0]                  stat_ff;      // Sticky status
	logic [2:0]                  nxt_stat;
	logic [2:0]                  stat_en_ff;   // Status enables
	logic [2:0]                  nxt_stat_en;
	logic [31:0]                 prdata_ff;    // Read data
	logic [NUM_SRC-1:0]          src_req_ff;   // Forwarded requests
	logic                        arb_valid_ff; // Registered winner
	logic [5:0]                  arb_id_ff;
	logic [2:0]                  arb_level_ff;

	// Implemented bits per word
	logic [NUM_WORDS-1:0][15:0]  impl_mask;
	logic [NUM_SRC-1:0]          impl_all;

	ieb_arb_if arb_bus ();  // Link to the arbiter

	// Word 0 holds only the three low sources
	assign impl_mask[0] = bitv(COMPARE1) | bitv(CAPTURE1)
		| bitv(EXT_PIN0);  // RQ4
	// Word 1 high byte
	assign impl_mask[1][15:8] = 8'((bitv(UART_B_TX) | bitv(UART_B_RX)
		| bitv(EXT_PIN2) | bitv(TIMER5) | bitv(TIMER4) | bitv(COMPARE4)
		| bitv(COMPARE3) | bitv(DMA_CH2)) >> 8);  // RQ5
	// Word 1 low byte, bit 2 left out
	assign impl_mask[1][7:0] = 8'(bitv(CAPTURE8) | bitv(CAPTURE7)
		| bitv(CONV_B) | bitv(EXT_PIN1) | bitv(CHG_NOTIFY)
		| bitv(I2C_A_MST) | bitv(I2C_A_SLV));  // RQ6 RQ3
	// Word 2 high byte, bit 13 left out
	assign impl_mask[2][15:8] = 8'((bitv(TIMER6) | bitv(DMA_CH4)
		| bitv(COMPARE8) | bitv(COMPARE7) | bitv(COMPARE6)
		| bitv(COMPARE5) | bitv(CAPTURE6)) >> 8);  // RQ7 RQ3
	// Word 2 low byte
	assign impl_mask[2][7:0] = 8'(bitv(CAPTURE5) | bitv(CAPTURE4)
		| bitv(CAPTURE3) | bitv(DMA_CH3) | bitv(CAN_A_EVT)
		| bitv(CAN_A_RX) | bitv(SPI_B_EVT) | bitv(SPI_B_ERR));  // RQ8
	assign impl_all = impl_mask;

	// Bus phases
	wire logic setup_ph = PSEL & ~PENABLE;     // Read data is fetched here
	wire logic acc_ph   = PSEL & PENABLE;      // Access completes here

	// Address decode
	logic [NUM_WORDS-1:0] hit_en;    // Enable words
	logic [NUM_WORDS-1:0] hit_flag;  // Flag words
	for (genvar w = 0; w < NUM_WORDS; w++) begin : g_dec
		assign hit_en[w]   = reg_hit(PADDR, ADDR_EN_BASE, w);
		assign hit_flag[w] = reg_hit(PADDR, ADDR_FLAG_BASE, w);
	end
	wire logic hit_prio = (PADDR >= ADDR_PRIO_BASE) && (PADDR < ADDR_PRIO_END)
		&& (PADDR[1:0] == 2'b00);
	wire logic [11:0] prio_off = PADDR - ADDR_PRIO_BASE;
	wire logic [3:0]  prio_row = prio_off[5:2];  // Row 0..11
	wire logic hit_stat     = reg_hit(PADDR, ADDR_STAT, 0);
	wire logic hit_stat_clr = reg_hit(PADDR, ADDR_STAT_CLR, 0);
	wire logic hit_stat_en  = reg_hit(PADDR, ADDR_STAT_EN, 0);
	wire logic hit_arb      = reg_hit(PADDR, ADDR_ARB, 0);
	wire logic mapped = (|hit_en) | (|hit_flag) | hit_prio | hit_stat
		| hit_stat_clr | hit_stat_en | hit_arb;

	// Completed writes and errors
	wire logic wr_acc  = acc_ph & PWRITE & mapped;
	wire logic bad_acc = acc_ph & ~mapped;

	// Zero wait states; unmapped accesses flagged as errors
	assign PREADY  = 1'b1;
	assign PSLVERR = bad_acc;
	assign PRDATA  = prdata_ff;

	// Read selection, clear-only register reads zero
	logic [15:0] rd_word;
	logic [2:0]  rd_prio [4];
	always_comb begin
		rd_word = 16'h0000;
		for (int f = 0; f < 4; f++) begin
			rd_prio[f] = prio_ff[(int'(prio_row) * 4 + f) % NUM_SRC];
		end
		for (int w = 0; w < NUM_WORDS; w++) begin
			// Enable bits read back what was written
			if (hit_en[w]) begin
				rd_word = en_ff[w];  // RQ9
			end
			// Flags read one once requested
			if (hit_flag[w]) begin
				rd_word = flag_ff[w];  // RQ10
			end
		end
		if (hit_prio) begin
			rd_word = prio_row_rd({rd_prio[3], rd_prio[2], rd_prio[1], rd_prio[0]});
		end else if (hit_stat) begin
			rd_word = {13'h0000, stat_ff};
		end else if (hit_stat_en) begin
			rd_word = {13'h0000, stat_en_ff};
		end else if (hit_arb) begin
			rd_word = {6'h00, arb_valid_ff, arb_level_ff, arb_id_ff};
		end
	end

	// Enable words; unimplemented bits never store
	always_comb begin
		for (int w = 0; w < NUM_WORDS; w++) begin
			if (wr_acc && hit_en[w]) begin
				nxt_en[w] = PWDATA[15:0] & impl_mask[w];  // RQ9 RQ3
			end else begin
				nxt_en[w] = en_ff[w];
			end
		end
	end

	// Flags: write one clears, a same-cycle event wins
	logic [NUM_WORDS-1:0][15:0] flag_clr;
	always_comb begin
		for (int w = 0; w < NUM_WORDS; w++) begin
			flag_clr[w] = (wr_acc && hit_flag[w]) ? PWDATA[15:0] : 16'h0000;
		end
		// Enable changes never touch the flags
		nxt_flag = ((flag_ff & ~flag_clr) | SRC_EVENT) & impl_mask;  // RQ10 RQ12
	end

	// Priority fields; unimplemented sources stay at zero
	always_comb begin
		for (int s = 0; s < NUM_SRC; s++) begin
			nxt_prio[s] = prio_ff[s];
			if (wr_acc && hit_prio && (int'(prio_row) == s / 4) && impl_all[s]) begin
				nxt_prio[s] = PWDATA[(s % 4) * 4 +: 3];  // RQ11
			end
		end
	end

	// Request gating toward arbitration
	assign arb_bus.req  = flag_ff & en_ff;  // RQ1 RQ12
	assign arb_bus.prio = prio_ff;

	ieb_arbiter u_arb (
		.arb (arb_bus)
	);

	// Status events
	wire logic ev_new  = |(arb_bus.req & ~src_req_ff);
	wire logic ev_over = |(SRC_EVENT & flag_ff & impl_mask);
	wire logic [2:0] stat_evt = {bad_acc, ev_over, ev_new};
	wire logic [2:0] stat_clr = (wr_acc && hit_stat_clr) ? PWDATA[2:0] : 3'h0;
	// Set wins over clear
	assign nxt_stat    = (stat_ff & ~stat_clr) | stat_evt;
	assign nxt_stat_en = (wr_acc && hit_stat_en) ? PWDATA[2:0] : stat_en_ff;

	// Bank registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			en_ff   <= {NUM_WORDS{EN_RST}};  // RQ2
			flag_ff <= {NUM_WORDS{FLAG_RST}};
		end else begin
			en_ff   <= nxt_en;
			flag_ff <= nxt_flag;
		end
	end

	// Priority registers, unimplemented slots held at zero
	always_ff @(posedge CLK) begin
		for (int s = 0; s < NUM_SRC; s++) begin
			if (RST) begin
				prio_ff[s] <= impl_all[s] ? PRIO_RST : PRIO_OFF;
			end else begin
				prio_ff[s] <= nxt_prio[s];
			end
		end
	end

	// Status, its enables and read data
	always_ff @(posedge CLK) begin
		if (RST) begin
			stat_ff    <= STAT_RST;
			stat_en_ff <= STAT_RST;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			stat_ff    <= nxt_stat;
			stat_en_ff <= nxt_stat_en;
			// Fetch during setup so data stands in the access cycle
			prdata_ff  <= setup_ph ? {16'h0000, rd_word} : prdata_ff;
		end
	end

	// Registered requests and winner
	always_ff @(posedge CLK) begin
		if (RST) begin
			src_req_ff   <= '0;
			arb_valid_ff <= 1'b0;
			arb_id_ff    <= 6'h00;
			arb_level_ff <= 3'h0;
		end else begin
			src_req_ff   <= arb_bus.req;  // RQ1
			arb_valid_ff <= arb_bus.win_valid;
			arb_id_ff    <= arb_bus.win_id;
			arb_level_ff <= arb_bus.win_level;
		end
	end

	// Outputs
	assign SRC_REQ   = src_req_ff;
	assign ARB_VALID = arb_valid_ff;
	assign ARB_ID    = arb_id_ff;
	assign ARB_LEVEL = arb_level_ff;
	assign IRQ       = |(stat_ff & stat_en_ff);

	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// Sources whose priority code lets them compete
	logic [NUM_SRC-1:0] prio_live;
	always_comb begin
		for (int s = 0; s < NUM_SRC; s++) begin
			prio_live[s] = (prio_ff[s] != PRIO_OFF);
		end
	end

	// Reset leaves every enable and request clear
	a_reset_clear: assert property (@(posedge CLK) disable iff (1'b0)  // RQ2
		RST |=> (en_ff == '0) && (SRC_REQ == '0))
		else $error("enable bank not clear after reset");
	// Reset also clears the flags
	a_reset_flags: assert property (@(posedge CLK) disable iff (1'b0)  // RQ2 RQ10
		RST |=> (flag_ff == '0))
		else $error("flags not clear after reset");

	// Gaps in the map never hold a one
	a_unimpl_zero: assert property ((en_ff & ~impl_mask) == '0)  // RQ3
		else $error("unimplemented enable bit set");
	a_flag_gap: assert property ((flag_ff & ~impl_mask) == '0)  // RQ3 RQ10
		else $error("unimplemented flag bit set");
	// Reads show zero in the gaps and the upper half
	a_rd_gap0: assert property ((setup_ph && hit_en[0]) |=>  // RQ4 RQ3
		(PRDATA & ~{16'h0000, impl_mask[0]}) == 32'h0000_0000)
		else $error("enable word 0 gap read as one");
	a_rd_gap1: assert property ((setup_ph && hit_en[1]) |=>  // RQ3
		(PRDATA & ~{16'h0000, impl_mask[1]}) == 32'h0000_0000)
		else $error("enable word 1 gap read as one");
	a_rd_gap2: assert property ((setup_ph && hit_en[2]) |=>  // RQ3
		(PRDATA & ~{16'h0000, impl_mask[2]}) == 32'h0000_0000)
		else $error("enable word 2 gap read as one");

	// Enable writes land, cut to the implemented positions
	a_en_write0: assert property ((wr_acc && hit_en[0]) |=>  // RQ4 RQ9
		en_ff[0] == ($past(PWDATA[15:0]) & impl_mask[0]))
		else $error("enable word 0 did not take write");
	a_en_write: assert property ((wr_acc && hit_en[1]) |=>  // RQ5 RQ6 RQ9
		en_ff[1] == ($past(PWDATA[15:0]) & impl_mask[1]))
		else $error("enable word 1 did not take write");
	a_en_write2: assert property ((wr_acc && hit_en[2]) |=>  // RQ7 RQ8 RQ9
		en_ff[2] == ($past(PWDATA[15:0]) & impl_mask[2]))
		else $error("enable word 2 did not take write");
	// Without a write the enables hold
	a_en_hold: assert property (!(wr_acc && (|hit_en)) |=> en_ff == $past(en_ff))  // RQ9
		else $error("enable bits changed without a write");

	// Forwarding is gated by the enables
	a_gate_mask: assert property (1'b1 |=>  // RQ1
		(SRC_REQ & ~$past(en_ff)) == '0)
		else $error("request passed a cleared enable");
	a_fwd_delay: assert property ((flag_ff[1][I2C_A_MST] && en_ff[1][I2C_A_MST])  // RQ12
		|=> SRC_REQ[16 + I2C_A_MST])
		else $error("flagged enabled source not forwarded");

	// Flags set on events, survive enable changes, clear on a one
	a_event_sets: assert property (((SRC_EVENT & impl_all) != '0) |=>  // RQ10
		((flag_ff & $past(SRC_EVENT & impl_all)) == $past(SRC_EVENT & impl_all)))
		else $error("event did not set its flag");
	a_flag_kept: assert property (1'b1 |=>  // RQ12
		(($past(flag_ff & ~flag_clr) & ~flag_ff) == '0))
		else $error("flag lost without a flag clear");
	a_flag_clear: assert property ((wr_acc && hit_flag[0] && !(|SRC_EVENT[15:0]))  // RQ10
		|=> (flag_ff[0] & $past(PWDATA[15:0])) == 16'h0000)
		else $error("flag not cleared by a one");

	// Priority codes and the winner
	a_prio_nonzero: assert property (ARB_VALID |-> ARB_LEVEL != PRIO_OFF)  // RQ11
		else $error("winner with disabled priority");
	a_prio_write: assert property ((wr_acc && hit_prio && (prio_row == 4'h0)) |=>  // RQ11
		prio_ff[EXT_PIN0] == $past(PWDATA[2:0]))
		else $error("priority code not written");
	a_prio_gap: assert property ((prio_ff[16 + 2] == PRIO_OFF)  // RQ3 RQ11
		&& (prio_ff[32 + 13] == PRIO_OFF))
		else $error("unimplemented source has a priority");
	a_arb_follow: assert property (1'b1 |=>  // RQ11 RQ12
		ARB_VALID == $past(|(arb_bus.req & prio_live)))
		else $error("winner valid out of step");
	a_win_live: assert property (ARB_VALID |-> SRC_REQ != '0)  // RQ12
		else $error("winner without a forwarded request");

	// Bus errors and the sticky status
	a_unmapped_err: assert property (bad_acc |-> PSLVERR ##1 stat_ff[ST_BUS_ERR])
		else $error("unmapped access not reported");
	a_stat_sticky: assert property ((bad_acc || (stat_ff[ST_BUS_ERR]
		&& !(wr_acc && hit_stat_clr && PWDATA[ST_BUS_ERR]))) |=> stat_ff[ST_BUS_ERR])
		else $error("bus error status lost");

	// Main scenarios
	c_req_fwd: cover property (SRC_EVENT[EXT_PIN0] ##1 1'b1 ##1 SRC_REQ[EXT_PIN0]);
	c_irq: cover property (!IRQ ##1 IRQ);
	c_flag_clr: cover property (wr_acc && hit_flag[2] && (PWDATA[15:0] != 16'h0000));
	c_top_prio: cover property (ARB_VALID && ARB_LEVEL == 3'h7);
	c_bus_err: cover property (bad_acc && !PWRITE);
endmodule // ieb_top
`default_nettype wire

// >>> tb/ieb_top_test.sv
`timescale 1ns/100ps
`default_nettype none
// Compare one value with its expectation, count it, report a mismatch
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("[FAIL] %0t ns: value %h expected %h", $time, (got), (exp)); end end

// Self-checking bench for the interrupt enable bank
module ieb_top_test
	import ieb_pkg::*;
();
	logic                clk;          // Core clock
	logic                rst;          // Synchronous reset
	logic                psel;         // APB select
	logic                penable;      // APB access phase
	logic                pwrite;       // APB direction
	logic [11:0]         paddr;        // APB byte address
	logic [31:0]         pwdata;       // APB write data
	logic [31:0]         prdata;       // APB read data
	logic                pready;       // APB ready
	logic                pslverr;      // APB error
	logic [NUM_SRC-1:0]  src_event;    // Source event inputs
	logic [NUM_SRC-1:0]  src_req;      // Gated requests
	logic                arb_valid;    // Some request wins
	logic [5:0]          arb_id;       // Winner index
	logic [2:0]          arb_level;    // Winner priority
	logic                irq;          // Status interrupt
	int                  miscompares;  // Mismatches seen
	int                  tests_run;    // Comparisons made
	logic [31:0]         rdat;         // Data of the last transfer
	logic                rerr;         // Error of the last transfer
	logic [NUM_SRC-1:0]  ex;           // Expected request vector
	logic                impl;         // Source slot is implemented
	// Implemented bits of each enable word
	logic [15:0] masks [3] = '{16'h0007, 16'hfffb, 16'hdfff};
	// Readback patterns
	logic [15:0] pats [4] = '{16'hffff, 16'ha5a5, 16'h5a5a, 16'h0000};

	// Device under test
	ieb_top ieb_top_inst (
		.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SRC_EVENT(src_event), .SRC_REQ(src_req),
		.ARB_VALID(arb_valid), .ARB_ID(arb_id), .ARB_LEVEL(arb_level), .IRQ(irq)
	);

	// 100 ns clock
	always #50 clk = ~clk;

	// Print the verdict and end the run
	task automatic report_and_stop();
		if (miscompares == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang here
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// One-cycle event on source i, then let the request settle
	task automatic pulse(input int i);
		@(posedge clk);
		src_event <= NUM_SRC'(1) << i;
		@(posedge clk);
		src_event <= '0;
		repeat (3) @(posedge clk);
	endtask

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		report_and_stop();
	end

	// Test sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		src_event = '0;
		miscompares = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Reset values of the enable words and a priority row
		for (int w = 0; w < 3; w++) begin
			apb(ADDR_EN_BASE + 12'(4 * w), 1'b0, 32'h0);
			`CHK(rdat, 32'h0)
		end
		apb(ADDR_PRIO_BASE, 1'b0, 32'h0);
		// Slot 3 of row 0 has no source, so its code stays off
		`CHK(rdat, {16'h0, 1'b0, PRIO_OFF, {3{1'b0, PRIO_RST}}})
		// Readback, with unimplemented positions held at zero
		for (int w = 0; w < 3; w++) begin
			for (int k = 0; k < 4; k++) begin
				apb(ADDR_EN_BASE + 12'(4 * w), 1'b1, {16'h0, pats[k]});
				apb(ADDR_EN_BASE + 12'(4 * w), 1'b0, 32'h0);
				`CHK(rdat, {16'h0, pats[k] & masks[w]})
			end
		end
		// Every source slot: enabled passes, disabled blocks, flag survives
		for (int i = 0; i < NUM_SRC; i++) begin
			impl = masks[i / 16][i % 16];
			ex = impl ? (NUM_SRC'(1) << i) : '0;
			apb(ADDR_EN_BASE + 12'(4 * (i / 16)), 1'b1, 32'h1 << (i % 16));
			pulse(i);
			`CHK(src_req, ex)
			`CHK(arb_valid, impl)
			if (impl) begin
				`CHK(arb_id, 6'(i))
				`CHK(arb_level, PRIO_RST)
			end
			apb(ADDR_EN_BASE + 12'(4 * (i / 16)), 1'b1, 32'h0);
			repeat (2) @(posedge clk);
			`CHK(src_req, {NUM_SRC{1'b0}})
			apb(ADDR_FLAG_BASE + 12'(4 * (i / 16)), 1'b0, 32'h0);
			`CHK(rdat, {16'h0, ex[(i / 16) * 16 +: 16]})
			apb(ADDR_FLAG_BASE + 12'(4 * (i / 16)), 1'b1, 32'h0000ffff);
			apb(ADDR_FLAG_BASE + 12'(4 * (i / 16)), 1'b0, 32'h0);
			`CHK(rdat, 32'h0)
		end
		// Priority code zero keeps a pending request out of arbitration
		apb(ADDR_PRIO_BASE, 1'b1, 32'h4440);
		apb(ADDR_EN_BASE, 1'b1, 32'h1);
		pulse(0);
		`CHK(src_req[0], 1'b1)
		`CHK(arb_valid, 1'b0)
		apb(ADDR_PRIO_BASE, 1'b1, 32'h4447);
		repeat (2) @(posedge clk);
		`CHK(arb_valid, 1'b1)
		`CHK(arb_level, 3'h7)
		apb(ADDR_ARB, 1'b0, 32'h0);
		`CHK(rdat, {22'h0, 1'b1, 3'h7, 6'h00})
		// Unmapped access raises the error status, masked then enabled
		apb(ADDR_STAT_CLR, 1'b1, 32'h7);
		apb(12'h0fc, 1'b0, 32'h0);
		`CHK(rerr, 1'b1)
		`CHK(rdat, 32'h0)
		apb(ADDR_STAT, 1'b0, 32'h0);
		`CHK(rdat[ST_BUS_ERR], 1'b1)
		`CHK(irq, 1'b0)
		apb(ADDR_STAT_EN, 1'b1, 32'h4);
		@(posedge clk);
		`CHK(irq, 1'b1)
		apb(ADDR_STAT_CLR, 1'b1, 32'h4);
		@(posedge clk);
		`CHK(irq, 1'b0)
		// Reset in mid-run clears every enable word
		for (int w = 0; w < 3; w++) begin
			apb(ADDR_EN_BASE + 12'(4 * w), 1'b1, 32'h0000ffff);
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int w = 0; w < 3; w++) begin
			apb(ADDR_EN_BASE + 12'(4 * w), 1'b0, 32'h0);
			`CHK(rdat, 32'h0)
		end
		report_and_stop();
	end
endmodule // ieb_top_test
`default_nettype wire
